//--- pkg/node_setup_pkg.sv
// Constants and types for the CAN node bit-rate and address setup block
// Operation
// - The rate code runs 0 to 8: 0 is automatic detection, 1 to 8 pick 10, 20, 50, 125, 250, 500, 800 kbps and 1 Mbps.
// - Address and rate code are latched once at start and later changes wait for the next power-up.
// - Addresses 1 to 126 are valid for network operation.
// - Address zero raises an address fault with a flashing error lamp and a fault indication.
// - In automatic mode the node only listens and steps its bit timing until it finds the rate in use.
// - Once the rate is found the node sends one boot-up message with its identifier and then goes pre-operational.
// - During detection the node transmits nothing, not even acknowledgements or error frames.
// - During detection the run and error lamps flicker alternately.
// - A detected rate is never stored and detection restarts at every power-up.
// - The node's rate must equal the network's rate or nothing can be exchanged.
// - Automatic detection exists only from option firmware revision 3102 onward.
// - The default rate code is 6, or 0 on regional variants whatever the drive firmware revision.
// - The default address is 99 on older drive firmware and 0 from revision 1012 on.
// - The communication-reset selection decides whether drive initialization restores defaults.
package node_setup_pkg;
   localparam logic [3:0] RATE_AUTO = 4'h0;
   localparam logic [3:0] RATE_MAX = 4'h8;
   localparam logic [3:0] RATE_DEF_STD = 4'h6;
   localparam logic [3:0] RATE_DEF_REGION = 4'h0;
   localparam logic [6:0] ADDR_MAX = 7'h7e;
   localparam logic [6:0] ADDR_DEF_OLD = 7'h63;
   localparam logic [6:0] ADDR_DEF_NEW = 7'h00;
   localparam logic [15:0] DRV_REV_NEW_ADDR = 16'h03f4;
   localparam logic [15:0] OPT_REV_AUTO = 16'h0c1e;
   // Register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h1;
   localparam logic [3:0] REG_IRQ = 4'h2;
   localparam logic [3:0] REG_MASK = 4'h3;
   localparam logic [3:0] REG_PEND = 4'h4;
   localparam int CTRL_RESET_ON_INIT = 0;
   localparam int CTRL_INIT = 1;
   localparam int CTRL_REGION = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;
   // Lamp timing at 40 MHz
   localparam int CLK_HZ = 40000000;
   localparam int FLICKER_MS = 50;
   localparam int FLASH_MS = 250;
   localparam int FLICKER_CYC = CLK_HZ / 1000 * FLICKER_MS;
   localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
   localparam int SCAN_US = 20;
   localparam int SCAN_CYC = CLK_HZ / 1000000 * SCAN_US;
   localparam int LOCK_FRAMES = 2;
   typedef enum logic [2:0]
   {
      ST_LATCH = 3'b000,
      ST_DETECT = 3'b001,
      ST_BOOT = 3'b011,
      ST_PREOP = 3'b010,
      ST_FAULT = 3'b110
   } state_type;
endpackage

//--- rtl/can_node_setup.sv
// CAN node start-up logic: rate selection, detection and address check
`timescale 1ns/10ps
module can_node_setup #(
   parameter int FLICKER_LEN = node_setup_pkg::FLICKER_CYC,
   parameter int FLASH_LEN = node_setup_pkg::FLASH_CYC,
   parameter int SCAN_LEN = node_setup_pkg::SCAN_CYC
)(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [6:0] node_identifier_setting,
   input wire logic [3:0] link_rate_select,
   input wire logic [15:0] option_fw_rev,
   input wire logic [15:0] drive_fw_rev,
   input wire logic frame_ok,
   input wire logic frame_err,
   input wire logic boot_done,
   input wire logic [3:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   output logic [3:0] rate_code,
   output logic [3:0] try_rate,
   output logic tx_enable,
   output logic boot_req,
   output logic [6:0] node_id,
   output logic preop,
   output logic run_lamp,
   output logic err_lamp,
   output logic address_fault_indication,
   output logic irq
);
   import node_setup_pkg::*;

   function automatic logic addr_valid(input logic [6:0] a);
      addr_valid = (a != 7'h00) && (a <= ADDR_MAX);
   endfunction

   state_type state_q, state_d;
   logic [6:0] id_q;
   logic [3:0] rate_q, try_q;
   logic [1:0] lock_q;
   logic [31:0] tick_q, scan_q;
   logic flick_q, flash_q;
   logic [2:0] irq_q, mask_q;
   logic comm_reset_q, region_q, pend_q;
   logic [6:0] pend_id_q;
   logic [3:0] pend_rate_q;
   logic [31:0] rdata_q;
   logic tx_q, boot_q, run_q, err_q, fault_q, irq_out_q, preop_q;

   ////////////////////////////////////////////////////////////////////
   wire auto_ok = option_fw_rev >= OPT_REV_AUTO;
   wire [3:0] sel_rate = (link_rate_select == RATE_AUTO && !auto_ok) ?
      RATE_DEF_STD : link_rate_select;
   wire rate_bad = sel_rate > RATE_MAX;
   wire [3:0] fixed_rate = rate_bad ? RATE_DEF_STD : sel_rate;
   wire heard = frame_ok && (state_q == ST_DETECT);
   wire want_auto = (sel_rate == RATE_AUTO);
   wire [6:0] def_id = (drive_fw_rev >= DRV_REV_NEW_ADDR) ?
      ADDR_DEF_NEW : ADDR_DEF_OLD;
   wire [3:0] def_rate = region_q ? RATE_DEF_REGION : RATE_DEF_STD;
   wire id_ok = addr_valid(node_identifier_setting);
   wire tick_end = (tick_q >= 32'(FLICKER_LEN - 1));
   wire flash_end = (scan_q >= 32'(FLASH_LEN - 1)) && (state_q == ST_FAULT);
   wire scan_end = (scan_q >= 32'(SCAN_LEN - 1)) && (state_q == ST_DETECT);
   wire locked = (state_q == ST_DETECT) && frame_ok &&
      (lock_q == 2'(LOCK_FRAMES - 1));
   wire wr_ctrl = bus_wr && bus_addr == REG_CTRL;
   wire wr_irq = bus_wr && bus_addr == REG_IRQ;
   wire wr_mask = bus_wr && bus_addr == REG_MASK;
   wire init_cmd = wr_ctrl && bus_wdata[CTRL_INIT];
   wire [2:0] ev = {locked, state_q == ST_LATCH && !id_ok,
      state_q == ST_BOOT && boot_done};
   wire [2:0] irq_d = (irq_q & ~(wr_irq ? bus_wdata[2:0] : 3'h0)) | ev;
   wire [31:0] rd_mux =
      bus_addr == REG_CTRL ? {29'h0, region_q, 1'b0, comm_reset_q} :
      bus_addr == REG_STAT ? {13'h0, state_q, try_q, rate_q, 1'b0, id_q} :
      bus_addr == REG_IRQ ? {29'h0, irq_q} :
      bus_addr == REG_MASK ? {29'h0, mask_q} :
      bus_addr == REG_PEND ? {20'h0, pend_rate_q, 1'b0, pend_id_q} : 32'h0;

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_LATCH:
            if (!id_ok)
               state_d = ST_FAULT;
            else if (want_auto)
               state_d = ST_DETECT;
            else
               state_d = ST_BOOT;
         ST_DETECT:
            if (locked)
               state_d = ST_BOOT;
         ST_BOOT:
            if (boot_done)
               state_d = ST_PREOP;
         ST_PREOP:
            state_d = ST_PREOP;
         ST_FAULT:
            state_d = ST_FAULT;
         default:
            state_d = ST_LATCH;
      endcase
   end

   // Settings are caught only in the latch state after reset
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         state_q <= ST_LATCH;
      else
         state_q <= state_d;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         id_q <= 7'h00;
         rate_q <= RATE_DEF_STD;
      end
      else if (state_q == ST_LATCH)
      begin
         id_q <= node_identifier_setting;
         rate_q <= fixed_rate;
      end
   end

   // Detection scans every fixed rate; found rate lives only in try_q
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         try_q <= 4'h1;
      else if (state_q == ST_LATCH)
         try_q <= want_auto ? 4'h1 : fixed_rate;
      else if (scan_end && !frame_ok)
         try_q <= (try_q == RATE_MAX) ? 4'h1 : try_q + 4'h1;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         lock_q <= 2'h0;
      else if (state_q != ST_DETECT || frame_err || scan_end)
         lock_q <= 2'h0;
      else if (frame_ok)
         lock_q <= lock_q + 2'h1;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         scan_q <= 32'h0;
      else if (scan_end || flash_end || heard || state_q == ST_LATCH)
         scan_q <= 32'h0;
      else
         scan_q <= scan_q + 32'h1;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tick_q <= 32'h0;
         flick_q <= 1'b0;
         flash_q <= 1'b0;
      end
      else
      begin
         tick_q <= tick_end ? 32'h0 : tick_q + 32'h1;
         flick_q <= flick_q ^ tick_end;
         flash_q <= flash_q ^ flash_end;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Software settings; new values wait for the next power-up
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         comm_reset_q <= 1'b0;
         region_q <= 1'b0;
         pend_q <= 1'b0;
         pend_id_q <= 7'h00;
         pend_rate_q <= RATE_DEF_STD;
      end
      else
      begin
         if (wr_ctrl)
         begin
            comm_reset_q <= bus_wdata[CTRL_RESET_ON_INIT];
            region_q <= bus_wdata[CTRL_REGION];
         end
         if (state_q == ST_LATCH && !pend_q)
         begin
            pend_id_q <= node_identifier_setting;
            pend_rate_q <= link_rate_select;
         end
         else if (init_cmd && comm_reset_q)
         begin
            pend_q <= 1'b1;
            pend_id_q <= def_id;
            pend_rate_q <= def_rate;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_q <= IRQ_RESET;
         mask_q <= MASK_RESET;
         irq_out_q <= 1'b0;
         rdata_q <= 32'h0;
      end
      else
      begin
         irq_q <= irq_d;
         if (wr_mask)
            mask_q <= bus_wdata[2:0];
         irq_out_q <= |(irq_d & mask_q);
         rdata_q <= bus_rd ? rd_mux : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_q <= 1'b0;
         boot_q <= 1'b0;
         run_q <= 1'b0;
         err_q <= 1'b0;
         fault_q <= 1'b0;
         preop_q <= 1'b0;
      end
      else
      begin
         tx_q <= state_d == ST_BOOT || state_d == ST_PREOP;
         boot_q <= state_d == ST_BOOT;
         preop_q <= state_d == ST_PREOP;
         fault_q <= state_d == ST_FAULT;
         run_q <= (state_d == ST_DETECT) ? flick_q :
            state_d == ST_PREOP;
         err_q <= (state_d == ST_DETECT) ? !flick_q :
            (state_d == ST_FAULT) ? flash_q : 1'b0;
      end
   end

   assign bus_rdata = rdata_q;
   assign rate_code = rate_q;
   assign try_rate = try_q;
   assign tx_enable = tx_q;
   assign boot_req = boot_q;
   assign node_id = id_q;
   assign preop = preop_q;
   assign run_lamp = run_q;
   assign err_lamp = err_q;
   assign address_fault_indication = fault_q;
   assign irq = irq_out_q;

   ////////////////////////////////////////////////////////////////////
   sequence detecting_s;
      state_q == ST_DETECT;
   endsequence
   sequence lock_s;
      detecting_s ##0 locked;
   endsequence

   quiet_detect_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      detecting_s ##1 state_q == ST_DETECT |-> !tx_enable)
      else $error("transmit enabled during detection");
   lamp_alt_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $past(state_q) == ST_DETECT && state_q == ST_DETECT
      |-> run_lamp != err_lamp)
      else $error("lamps not alternating");
   boot_after_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      lock_s |=> boot_req && tx_enable)
      else $error("no boot request after lock");
   zero_addr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      state_q == ST_LATCH && node_identifier_setting == 7'h00
      |-> ##2 address_fault_indication)
      else $error("address fault missing");
   id_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      state_q != ST_LATCH |=> $stable(node_id))
      else $error("node id changed after start");
   rate_range_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      state_q != ST_LATCH |-> rate_code <= RATE_MAX)
      else $error("rate code out of range");
   valid_run_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      preop |-> node_id != 7'h00 && node_id <= ADDR_MAX)
      else $error("preop with bad address");
   old_fw_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      state_q == ST_LATCH && option_fw_rev < OPT_REV_AUTO
      |=> state_q != ST_DETECT)
      else $error("detection on old firmware");
endmodule

//--- dv/can_net_model.sv
// Far-side bus model: traffic source and boot message sink
`timescale 1ns/10ps
module can_net_model (
   input wire logic ref_clk,
   input wire logic [3:0] net_rate,
   input wire logic [3:0] try_rate,
   input wire logic tx_enable,
   input wire logic boot_req,
   output logic frame_ok,
   output logic frame_err,
   output logic boot_done
);
   logic [4:0] tick_q = 5'h00;
   logic [1:0] wait_q = 2'h0;
   // Identifier of the traffic node, kept apart from the node under test
   localparam logic [6:0] PEER_ID = 7'h01;
   always @(posedge ref_clk)
   begin
      tick_q <= tick_q + 5'h01;
      // A second node at the network rate keeps frames coming
      frame_ok <= (tick_q[1:0] == 2'h3) && (try_rate == net_rate);
      frame_err <= (tick_q == 5'h1f) && (try_rate != net_rate);
      wait_q <= (boot_req && tx_enable) ? wait_q + 2'h1 : 2'h0;
      boot_done <= (wait_q == 2'h2) && boot_req;
   end
endmodule

//--- dv/can_node_bitrate_id_setup_tb_top.sv
// Self-checking bench for the CAN node start-up block
`timescale 1ns/10ps
module can_node_bitrate_id_setup_tb_top;
   import node_setup_pkg::*;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [6:0] id_set = 7'h00;
   logic [3:0] code_set = 4'h0;
   logic [15:0] opt_rev = 16'h0c1e;
   logic [15:0] drv_rev = 16'h03f4;
   logic [3:0] net_rate = 4'h1;
   logic [3:0] bus_addr = 4'h0;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic frame_ok, frame_err, boot_done, tx_enable, boot_req, preop;
   logic run_lamp, err_lamp, afi, irq;
   logic [31:0] bus_rdata, rd_q;
   logic [3:0] rate_code, try_rate;
   logic [6:0] node_id;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int bad = 0;
   always #12.5 ref_clk = ~ref_clk;
   can_node_setup #(.FLICKER_LEN(4), .FLASH_LEN(8), .SCAN_LEN(16)) u_dut (
      .ref_clk(ref_clk), .arst_n(arst_n),
      .node_identifier_setting(id_set), .link_rate_select(code_set),
      .option_fw_rev(opt_rev), .drive_fw_rev(drv_rev),
      .frame_ok(frame_ok), .frame_err(frame_err), .boot_done(boot_done),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rate_code(rate_code),
      .try_rate(try_rate), .tx_enable(tx_enable), .boot_req(boot_req),
      .node_id(node_id), .preop(preop), .run_lamp(run_lamp),
      .err_lamp(err_lamp), .address_fault_indication(afi), .irq(irq));
   can_net_model u_net (.ref_clk(ref_clk), .net_rate(net_rate),
      .try_rate(try_rate), .tx_enable(tx_enable), .boot_req(boot_req),
      .frame_ok(frame_ok), .frame_err(frame_err), .boot_done(boot_done));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Power cycle with new settings presented during reset
   task automatic power_up(input logic [6:0] id, input logic [3:0] code,
      input logic [15:0] orv, input logic [3:0] nr);
      @(posedge ref_clk);
      arst_n <= 1'b0;
      net_rate <= nr;
      id_set <= id;
      code_set <= code;
      opt_rev <= orv;
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1 rd_q = bus_rdata;
   endtask
   task automatic wait_preop();
      int n;
      n = 0;
      while (preop !== 1'b1 && n < 600)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      #1;
      chk("preop", preop, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_fixed();
      for (int c = 1; c <= 8; c++)
      begin
         power_up(7'h7e, c[3:0], 16'h0c1e, c[3:0]);
         chk("rate_code", rate_code, c);
         chk("try_rate", try_rate, c);
         wait_preop();
         chk("node_id", node_id, 7'h7e);
         chk("tx on", tx_enable, 1'b1);
         chk("fault", afi, 1'b0);
      end
      @(posedge ref_clk);
      id_set <= 7'h05;
      code_set <= 4'h2;
      repeat (20) @(posedge ref_clk);
      #1;
      chk("held rate", rate_code, 4'h8);
      chk("held id", node_id, 7'h7e);
      $display("test fixed done");
   endtask
   task automatic t_auto();
      logic [3:0] first;
      power_up(7'h09, RATE_AUTO, 16'h0c1e, 4'h7);
      first = try_rate;
      bad = 0;
      repeat (60)
      begin
         @(posedge ref_clk);
         #1;
         if (tx_enable !== 1'b0 || run_lamp === err_lamp) bad++;
      end
      chk("quiet flicker", bad, 0);
      chk("scan step", try_rate != first, 1'b1);
      wait_preop();
      chk("found rate", try_rate, 4'h7);
      chk("auto code", rate_code, RATE_AUTO);
      chk("boot id", node_id, 7'h09);
      chk("unique id", node_id != u_net.PEER_ID, 1'b1);
      repeat (30) @(posedge ref_clk);
      #1;
      chk("one boot", boot_req, 1'b0);
      rd(REG_IRQ);
      chk("irq bits", rd_q[2:0], 3'h5);
      wr(REG_IRQ, 32'h1);
      rd(REG_IRQ);
      chk("irq clear", rd_q[2:0], 3'h4);
      power_up(7'h09, RATE_AUTO, 16'h0c1e, 4'h7);
      chk("restart", try_rate, 4'h1);
      chk("not preop", preop, 1'b0);
      wait_preop();
      $display("test auto done");
   endtask
   task automatic t_old_fw();
      power_up(7'h09, RATE_AUTO, 16'h0c1d, 4'h6);
      chk("old fw code", rate_code, RATE_DEF_STD);
      wait_preop();
      chk("old fw rate", try_rate, 4'h6);
      power_up(7'h09, 4'h9, 16'h0c1e, 4'h6);
      chk("bad code", rate_code, RATE_DEF_STD);
      chk("bad code try", try_rate, 4'h6);
      wait_preop();
      $display("test old firmware done");
   endtask
   task automatic t_addr0();
      power_up(7'h00, 4'h6, 16'h0c1e, 4'h6);
      chk("addr fault", afi, 1'b1);
      bad = 0;
      repeat (40)
      begin
         @(posedge ref_clk);
         #1;
         if (err_lamp === 1'b1) bad++;
      end
      chk("err flash", bad > 0 && bad < 40, 1'b1);
      chk("run off", run_lamp, 1'b0);
      rd(REG_IRQ);
      chk("fault bit", rd_q[1], 1'b1);
      chk("irq masked", irq, 1'b0);
      wr(REG_MASK, 32'h2);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("irq on", irq, 1'b1);
      wr(REG_MASK, 32'h0);
      $display("test address zero done");
   endtask
   task automatic t_init();
      power_up(7'h7e, 4'h6, 16'h0c1e, 4'h6);
      rd(REG_PEND);
      chk("pend", rd_q[11:0], 12'h67e);
      wr(REG_CTRL, 32'h2);
      rd(REG_PEND);
      chk("keep", rd_q[11:0], 12'h67e);
      wr(REG_CTRL, 32'h1);
      wr(REG_CTRL, 32'h3);
      rd(REG_PEND);
      chk("new def", rd_q[11:0], 12'h600);
      wr(REG_CTRL, 32'h5);
      wr(REG_CTRL, 32'h7);
      rd(REG_PEND);
      chk("region", rd_q[11:0], 12'h000);
      wr(REG_CTRL, 32'h1);
      @(posedge ref_clk);
      drv_rev <= 16'h03f3;
      wr(REG_CTRL, 32'h3);
      rd(REG_PEND);
      chk("old def", rd_q[11:0], 12'h663);
      rd(4'hf);
      chk("unmapped", rd_q, 32'h0);
      chk("live rate", rate_code, 4'h6);
      $display("test init done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         print_verdict();
      end
   end
   initial
   begin
      t_fixed();
      t_auto();
      t_old_fw();
      t_addr0();
      t_init();
      print_verdict();
   end
endmodule
